//--- logic/doc_pkg.sv
// shared constants, register map and types of the display output control block
package doc_pkg;

    localparam int unsigned ADR_W        = 12;
    localparam int unsigned DAT_W        = 32;
    localparam int unsigned LINE_W       = 12;
    localparam int unsigned CHAN_W       = 8;
    localparam int unsigned FIELD_W      = 3;
    localparam int unsigned DIV_W        = 8;

    localparam logic [ADR_W-1:0] OFS_SYNC_A     = 12'h04c;
    localparam logic [ADR_W-1:0] OFS_SYNC_B     = 12'h050;
    localparam logic [ADR_W-1:0] OFS_SWAP       = 12'h054;
    localparam logic [ADR_W-1:0] OFS_ORIENT     = 12'h058;
    localparam logic [ADR_W-1:0] OFS_LINES      = 12'h05c;
    localparam logic [ADR_W-1:0] OFS_DITHER     = 12'h060;
    localparam logic [ADR_W-1:0] OFS_PCLK_DIV   = 12'h070;
    localparam logic [ADR_W-1:0] OFS_LINE_LEN   = 12'h100;
    localparam logic [ADR_W-1:0] OFS_FRAME_LEN  = 12'h104;

    localparam logic [LINE_W-1:0]  RST_SYNC_A    = 12'h000;
    localparam logic [LINE_W-1:0]  RST_SYNC_B    = 12'h00a;
    localparam logic [2:0]         RST_ORIENT    = 3'h0;
    localparam logic [8:0]         RST_LINES     = 9'h000;
    localparam logic               RST_DITHER    = 1'b1;
    localparam logic [DIV_W-1:0]   RST_PCLK_DIV  = 8'h00;
    localparam logic [LINE_W-1:0]  RST_LINE_LEN  = 12'h224;
    localparam logic [LINE_W-1:0]  RST_FRAME_LEN = 12'h124;

    localparam int unsigned RED_LSB = 6;
    localparam int unsigned GRN_LSB = 3;
    localparam int unsigned BLU_LSB = 0;

    localparam logic [1:0] SWAP_CODE_IDLE  = 2'b00;
    localparam logic [1:0] SWAP_CODE_LINE  = 2'b01;
    localparam logic [1:0] SWAP_CODE_FRAME = 2'b10;

    typedef enum logic [1:0] {
        SWAP_IDLE,
        SWAP_AT_LINE,
        SWAP_AT_FRAME
    } doc_swap_t;

    typedef struct packed {
        logic [CHAN_W-1:0] r;
        logic [CHAN_W-1:0] g;
        logic [CHAN_W-1:0] b;
    } doc_rgb_t;

    typedef struct packed {
        logic       phase_a;
        logic       phase_b;
    } doc_fsync_t;

endpackage

//--- logic/doc_pclk_div.sv
// pixel clock divider producing the pixel tick and the pixel clock pin
`timescale 1ns/10ps
`default_nettype none
module doc_pclk_div
    import doc_pkg::*;
(
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [DIV_W-1:0] div_in,
    output var  logic             tick_out,
    output var  logic             pclk_out
);
    logic [DIV_W-1:0] count;
    wire              stopped  = (div_in == '0);
    wire              wrap     = (count >= div_in - 8'h01);
    wire [DIV_W-1:0]  next_count = (stopped || wrap) ? '0 : count + 8'h01;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count    <= '0;
            tick_out <= 1'b0;
            pclk_out <= 1'b0;
        end else begin
            count    <= next_count;
            tick_out <= !stopped && wrap;
            pclk_out <= !stopped && (next_count < (div_in >> 1));
        end
    end

    // a zero divisor must hold the pin low, not freeze it high
    a_pclk_stopped: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (div_in == '0) [*2] |-> !pclk_out && !tick_out)
        else $error("pixel clock runs with zero divisor");
endmodule
`default_nettype wire

//--- logic/doc_output_ctrl.sv
// display output control: register file, swap handshake, frame sync and colour output
// Function
// - dither bit 1 dithers colour output, 0 passes it plain; bit reads back.
// - line-count register: red bits 8-6, green 5-3, blue 2-0.
// - field zero drives all eight lines; binary 111 drives seven lines.
// - orientation 000-011: landscape, inverted landscape, portrait, inverted portrait.
// - orientation with top bit set selects the mirrored versions.
// - orientation steers only rendered output, never the touch transform.
// - swap code 01 starts the new list when the current line ends.
// - swap code 10 starts the new list when the current frame ends.
// - swap field reads nonzero while pending, zero once buffer is free.
// - phase b sync setting gives its line count right after the phase a lines.
// - phase a sync setting gives its line count at frame start.
// - pixel clock is main clock over 8-bit divisor, except that divisor 1 holds the pin low; zero stops it.
`timescale 1ns/10ps
`default_nettype none
module doc_output_ctrl
    import doc_pkg::*;
(
    input  wire logic             CLK_IN,
    input  wire logic             RST_N_IN,
    input  wire logic             WB_CYC_IN,
    input  wire logic             WB_STB_IN,
    input  wire logic             WB_WE_IN,
    input  wire logic [ADR_W-1:0] WB_ADR_IN,
    input  wire logic [3:0]       WB_SEL_IN,
    input  wire logic [DAT_W-1:0] WB_DAT_IN,
    output var  logic [DAT_W-1:0] WB_DAT_OUT,
    output var  logic             WB_ACK_OUT,
    input  wire doc_rgb_t         PIXEL_IN,
    output var  doc_rgb_t         RGB_OUT,
    output var  logic             PCLK_OUT,
    output var  doc_fsync_t       FSYNC_OUT,
    output var  logic [2:0]       ORIENT_OUT,
    output var  logic             LIST_START_OUT
);
    // registers
    logic [LINE_W-1:0] sync_a;
    logic [LINE_W-1:0] sync_b;
    doc_swap_t         swap;
    logic [2:0]        orient;
    logic [8:0]        lines;
    logic              dither;
    logic [DIV_W-1:0]  pclk_div;
    logic [LINE_W-1:0] line_len;
    logic [LINE_W-1:0] frame_len;
    logic [LINE_W-1:0] hcount;
    logic [LINE_W-1:0] vcount;

    // byte-lane merge of a write into a stored word
    function automatic logic [DAT_W-1:0] merge(input logic [DAT_W-1:0] old_v,
                                               input logic [DAT_W-1:0] new_v,
                                               input logic [3:0] sel);
        logic [DAT_W-1:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // mask of driven lines for one colour field
    function automatic logic [CHAN_W-1:0] line_mask(input logic [FIELD_W-1:0] fld);
        logic [3:0] keep;
        keep = (fld == '0) ? 4'h8 : {1'b0, fld};
        return 8'hff << (4'h8 - keep);
    endfunction

    // ordered dither: the 2x2 threshold tops out two lines below the lowest driven line, one line below for a seven-line field
    function automatic logic [CHAN_W-1:0] shade(input logic [CHAN_W-1:0] chan,
                                                input logic [FIELD_W-1:0] fld,
                                                input logic en,
                                                input logic [1:0] thr);
        logic [CHAN_W-1:0] m;
        logic [8:0]        sum;
        logic [CHAN_W-1:0] add;
        m   = line_mask(fld);
        add = 8'h00;
        if (en && m != 8'hff) begin
            add = ({6'h00, thr} << 6) & ~m;
            for (int i = 0; i < 7; i++) begin
                if (!m[i] && m[i+1]) begin
                    add = 8'(({6'h00, thr} << i) >> 2) | add & 8'h00;
                    if (i == 0) begin
                        add = {7'h00, thr[1]};
                    end
                end
            end
        end
        sum = {1'b0, chan} + {1'b0, add};
        return (sum[8] ? 8'hff : sum[7:0]) & m;
    endfunction

    // bus decode
    wire bus_req   = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
    wire bus_wr    = bus_req && WB_WE_IN;
    wire wr_sync_a = bus_wr && (WB_ADR_IN == OFS_SYNC_A);
    wire wr_sync_b = bus_wr && (WB_ADR_IN == OFS_SYNC_B);
    wire wr_swap   = bus_wr && (WB_ADR_IN == OFS_SWAP) && WB_SEL_IN[0];
    wire wr_orient = bus_wr && (WB_ADR_IN == OFS_ORIENT);
    wire wr_lines  = bus_wr && (WB_ADR_IN == OFS_LINES);
    wire wr_dither = bus_wr && (WB_ADR_IN == OFS_DITHER);
    wire wr_div    = bus_wr && (WB_ADR_IN == OFS_PCLK_DIV);
    wire wr_hlen   = bus_wr && (WB_ADR_IN == OFS_LINE_LEN);
    wire wr_vlen   = bus_wr && (WB_ADR_IN == OFS_FRAME_LEN);

    wire [1:0] swap_code = (swap == SWAP_AT_LINE)  ? SWAP_CODE_LINE :
                           (swap == SWAP_AT_FRAME) ? SWAP_CODE_FRAME : SWAP_CODE_IDLE;

    logic [DAT_W-1:0] rd_word;
    always_comb begin
        rd_word = '0;
        unique case (WB_ADR_IN)
            OFS_SYNC_A:    rd_word = {20'h0, sync_a};
            OFS_SYNC_B:    rd_word = {20'h0, sync_b};
            OFS_SWAP:      rd_word = {30'h0, swap_code};
            OFS_ORIENT:    rd_word = {29'h0, orient};
            OFS_LINES:     rd_word = {23'h0, lines};
            OFS_DITHER:    rd_word = {31'h0, dither};
            OFS_PCLK_DIV:  rd_word = {24'h0, pclk_div};
            OFS_LINE_LEN:  rd_word = {20'h0, line_len};
            OFS_FRAME_LEN: rd_word = {20'h0, frame_len};
            default:       rd_word = '0;
        endcase
    end

    // pixel clock and raster counters
    logic tick;
    doc_pclk_div u_div (
        .clk_in   (CLK_IN),
        .rst_n_in (RST_N_IN),
        .div_in   (pclk_div),
        .tick_out (tick),
        .pclk_out (PCLK_OUT)
    );

    wire line_end  = tick && (hcount >= line_len - 12'h001);
    wire frame_end = line_end && (vcount >= frame_len - 12'h001);
    wire [LINE_W-1:0] next_hcount = line_end ? '0 : (tick ? hcount + 12'h001 : hcount);
    wire [LINE_W-1:0] next_vcount = frame_end ? '0 : (line_end ? vcount + 12'h001 : vcount);
    wire [LINE_W:0]   b_end       = {1'b0, sync_a} + {1'b0, sync_b};
    wire              next_ph_a   = ({1'b0, next_vcount} < {1'b0, sync_a});
    wire              next_ph_b   = !next_ph_a && ({1'b0, next_vcount} < b_end);

    // swap handshake: a new request in the boundary cycle wins over completion
    wire swap_done = (swap == SWAP_AT_LINE && line_end) || (swap == SWAP_AT_FRAME && frame_end);
    doc_swap_t next_swap;
    always_comb begin
        next_swap = swap;
        if (swap_done) begin
            next_swap = SWAP_IDLE;
        end
        // codes 00 and 11 are not expected; they leave the field alone
        if (wr_swap && WB_DAT_IN[1:0] == SWAP_CODE_LINE) begin
            next_swap = SWAP_AT_LINE;
        end else if (wr_swap && WB_DAT_IN[1:0] == SWAP_CODE_FRAME) begin
            next_swap = SWAP_AT_FRAME;
        end
    end

    wire [1:0] thr = {hcount[0] ^ vcount[0], vcount[0]};
    doc_rgb_t next_rgb;
    assign next_rgb.r = shade(PIXEL_IN.r, lines[RED_LSB +: FIELD_W], dither, thr);
    assign next_rgb.g = shade(PIXEL_IN.g, lines[GRN_LSB +: FIELD_W], dither, thr);
    assign next_rgb.b = shade(PIXEL_IN.b, lines[BLU_LSB +: FIELD_W], dither, thr);

    wire [DAT_W-1:0] wd_sync_a = merge({20'h0, sync_a}, WB_DAT_IN, WB_SEL_IN);
    wire [DAT_W-1:0] wd_sync_b = merge({20'h0, sync_b}, WB_DAT_IN, WB_SEL_IN);
    wire [DAT_W-1:0] wd_orient = merge({29'h0, orient}, WB_DAT_IN, WB_SEL_IN);
    wire [DAT_W-1:0] wd_lines  = merge({23'h0, lines}, WB_DAT_IN, WB_SEL_IN);
    wire [DAT_W-1:0] wd_dither = merge({31'h0, dither}, WB_DAT_IN, WB_SEL_IN);
    wire [DAT_W-1:0] wd_div    = merge({24'h0, pclk_div}, WB_DAT_IN, WB_SEL_IN);
    wire [DAT_W-1:0] wd_hlen   = merge({20'h0, line_len}, WB_DAT_IN, WB_SEL_IN);
    wire [DAT_W-1:0] wd_vlen   = merge({20'h0, frame_len}, WB_DAT_IN, WB_SEL_IN);

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            WB_ACK_OUT <= 1'b0;
            WB_DAT_OUT <= '0;
        end else begin
            WB_ACK_OUT <= bus_req;
            WB_DAT_OUT <= bus_req ? rd_word : '0;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            sync_a    <= RST_SYNC_A;
            sync_b    <= RST_SYNC_B;
            orient    <= RST_ORIENT;
            lines     <= RST_LINES;
            dither    <= RST_DITHER;
            pclk_div  <= RST_PCLK_DIV;
            line_len  <= RST_LINE_LEN;
            frame_len <= RST_FRAME_LEN;
        end else begin
            sync_a    <= wr_sync_a ? wd_sync_a[LINE_W-1:0] : sync_a;
            sync_b    <= wr_sync_b ? wd_sync_b[LINE_W-1:0] : sync_b;
            orient    <= wr_orient ? wd_orient[2:0] : orient;
            lines     <= wr_lines ? wd_lines[8:0] : lines;
            dither    <= wr_dither ? wd_dither[0] : dither;
            pclk_div  <= wr_div ? wd_div[DIV_W-1:0] : pclk_div;
            line_len  <= wr_hlen ? wd_hlen[LINE_W-1:0] : line_len;
            frame_len <= wr_vlen ? wd_vlen[LINE_W-1:0] : frame_len;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            swap           <= SWAP_IDLE;
            hcount         <= '0;
            vcount         <= '0;
            FSYNC_OUT      <= '0;
            RGB_OUT        <= '0;
            ORIENT_OUT     <= RST_ORIENT;
            LIST_START_OUT <= 1'b0;
        end else begin
            swap              <= next_swap;
            hcount            <= next_hcount;
            vcount            <= next_vcount;
            FSYNC_OUT.phase_a <= next_ph_a;
            FSYNC_OUT.phase_b <= next_ph_b;
            RGB_OUT           <= tick ? next_rgb : RGB_OUT;
            // orientation goes to the renderer only; touch mapping has no input from here
            ORIENT_OUT        <= orient;
            LIST_START_OUT    <= swap_done;
        end
    end

    // checks
    sequence s_line_swap_req;
        wr_swap && WB_DAT_IN[1:0] == SWAP_CODE_LINE;
    endsequence
    sequence s_frame_swap_req;
        wr_swap && WB_DAT_IN[1:0] == SWAP_CODE_FRAME;
    endsequence

    a_swap_line_done: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        swap == SWAP_AT_LINE && line_end && !wr_swap |=> swap == SWAP_IDLE && LIST_START_OUT)
        else $error("line swap not finished at line end");
    a_swap_frame_hold: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        swap == SWAP_AT_FRAME && !frame_end && !wr_swap |=> swap == SWAP_AT_FRAME && !LIST_START_OUT)
        else $error("frame swap left before frame end");
    a_swap_pending_read: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        s_line_swap_req ##1 (swap != SWAP_IDLE) |-> rd_word[1:0] != SWAP_CODE_IDLE || WB_ADR_IN != OFS_SWAP)
        else $error("pending swap reads as zero");
    a_swap_set_wins: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        s_line_swap_req |=> swap == SWAP_AT_LINE)
        else $error("swap request lost");
    a_dither_plain: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        tick && !dither |=> RGB_OUT.r == ($past(PIXEL_IN.r) & line_mask($past(lines[RED_LSB +: FIELD_W]))))
        else $error("undithered red differs from input");
    a_full_lines: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        tick && !dither && lines == '0 |=> RGB_OUT == $past(PIXEL_IN))
        else $error("zero field does not drive all lines");
    a_low_lines_off: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        tick && lines[BLU_LSB +: FIELD_W] == 3'h1 |=> RGB_OUT.b[6:0] == 7'h00)
        else $error("undriven blue line active");
    a_phase_a_lines: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        $past(vcount) < sync_a && $stable(sync_a) && !$past(line_end) |-> FSYNC_OUT.phase_a && !FSYNC_OUT.phase_b)
        else $error("phase a missing inside its lines");
    a_orient_follow: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        wr_orient && WB_SEL_IN[0] |-> ##2 ORIENT_OUT == $past(WB_DAT_IN[2:0], 2))
        else $error("orientation not passed on");
    a_ack_single: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        WB_ACK_OUT |=> !WB_ACK_OUT)
        else $error("ack held longer than one cycle");
    a_ack_follows: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        bus_req |=> WB_ACK_OUT)
        else $error("request not answered in the next cycle");
    a_swap_frame_done: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        swap == SWAP_AT_FRAME && frame_end && !wr_swap |=> swap == SWAP_IDLE && LIST_START_OUT)
        else $error("frame swap not finished at frame end");
    a_frame_set_wins: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        s_frame_swap_req |=> swap == SWAP_AT_FRAME)
        else $error("frame swap request lost");
    a_start_from_pending: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        LIST_START_OUT |-> $past(swap) != SWAP_IDLE)
        else $error("list start without a pending swap");
    a_swap_idle_zero: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        bus_req && !WB_WE_IN && WB_ADR_IN == OFS_SWAP && swap == SWAP_IDLE |=> WB_DAT_OUT == '0)
        else $error("free buffer reads nonzero");
    a_dither_readback: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        bus_req && !WB_WE_IN && WB_ADR_IN == OFS_DITHER |=> WB_ACK_OUT && WB_DAT_OUT == {31'h0, $past(dither)})
        else $error("dither bit reads back wrong");
    a_seven_lines: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        tick && lines[RED_LSB +: FIELD_W] == 3'h7 |=> RGB_OUT.r[0] == 1'b0)
        else $error("seven-line red drives its lowest line");
    a_green_mask: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        tick && lines[GRN_LSB +: FIELD_W] == 3'h4 |=> RGB_OUT.g[3:0] == 4'h0)
        else $error("undriven green line active");
    // the first edge after reset still shows the reset value, so that edge is left out
    a_phase_b_lines: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        $past(RST_N_IN) && $past(vcount) >= sync_a && ({1'b0, $past(vcount)} < b_end) && $stable(sync_a)
        && $stable(sync_b) && !$past(line_end) |-> FSYNC_OUT.phase_b && !FSYNC_OUT.phase_a)
        else $error("phase b missing inside its lines");
endmodule
`default_nettype wire

//--- dv/doc_panel_model.sv
// renderer and panel stand-in: presents pixels and counts display list restarts
`timescale 1ns/10ps
`default_nettype none
module doc_panel_model
    import doc_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire doc_rgb_t   pixel_set_in,
    input  wire logic       list_start_in,
    output var  doc_rgb_t   pixel_out,
    output var  logic [7:0] starts_out
);
    // pixels come from a register, as a real renderer's would, never straight from the bench
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pixel_out  <= '0;
            starts_out <= '0;
        end else begin
            pixel_out <= pixel_set_in;
            if (list_start_in) begin
                starts_out <= starts_out + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

//--- dv/doc_output_ctrl_tb_top.sv
// self-checking bench for the display output control block
`timescale 1ns/10ps
`default_nettype none
module doc_output_ctrl_tb_top;
    import doc_pkg::*;
    logic             clk, rst_n, cyc, stb, we, ack, pclk, lstart;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [DAT_W-1:0] wdat, rdat, v;
    doc_rgb_t         pix_set, pix, rgb;
    doc_fsync_t       fsync;
    logic [2:0]       orient, fr, fg, fb;
    logic [7:0]       starts;
    logic [DAT_W-1:0] exp_q[$];
    int               fail_count, checked, n, hits;
    logic [ADR_W-1:0] ofs[5] = '{OFS_SYNC_A, OFS_SYNC_B, OFS_ORIENT, OFS_LINES, OFS_DITHER};
    logic [DAT_W-1:0] msk[5] = '{32'h00000fff, 32'h00000fff, 32'h00000007, 32'h000001ff, 32'h00000001};

    doc_output_ctrl dut (.CLK_IN(clk), .RST_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
        .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
        .PIXEL_IN(pix), .RGB_OUT(rgb), .PCLK_OUT(pclk), .FSYNC_OUT(fsync), .ORIENT_OUT(orient),
        .LIST_START_OUT(lstart));
    doc_panel_model panel (.clk_in(clk), .rst_n_in(rst_n), .pixel_set_in(pix_set), .list_start_in(lstart),
        .pixel_out(pix), .starts_out(starts));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input logic [DAT_W-1:0] got, input logic [DAT_W-1:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // classic cycle: request held until ack is sampled, released at that edge only
    task automatic bus(input logic w, input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    task automatic wr(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, '0);
    endtask

    // read results are matched against the oldest note as each ack appears
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) check(rdat, exp_q.pop_front());
    end

    function automatic logic [7:0] lmask(input logic [2:0] f);
        return (f == 3'h0) ? 8'hff : ~(8'hff >> f);
    endfunction
    task automatic count_rises(output int r);
        logic prev;
        r = 0;
        @(posedge clk);
        prev = pclk;
        repeat (40) begin
            @(posedge clk);
            if (pclk === 1'b1 && prev === 1'b0) r++;
            prev = pclk;
        end
    endtask
    task automatic wait_start(input int limit, output int c);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (lstart !== 1'b1 && c < limit);
    endtask
    task automatic run_len(input logic ph_a, output int c);
        c = 0;
        while ((ph_a ? fsync.phase_a : fsync.phase_b) === 1'b1) begin
            c++;
            @(posedge clk);
        end
    endtask

    task automatic give_verdict();
        $display("counts: checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // whole sequence needs about 1200 cycles; a hang is cut off well beyond that
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        give_verdict();
    end

    initial begin
        cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = '0; sel = '0; wdat = '0; pix_set = '0;
        rst_n = 1'b0; fail_count = 0; checked = 0;
        void'($urandom(2769));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_SYNC_A, 32'h0);
        rd(OFS_SYNC_B, 32'h0000000a);
        rd(OFS_SWAP, 32'h0);
        rd(OFS_ORIENT, 32'h0);
        rd(OFS_LINES, 32'h0);
        rd(OFS_DITHER, 32'h1);
        rd(12'h0f0, 32'h0);
        count_rises(n);
        check(32'(n), 32'h0);
        check(32'(pclk), 32'h0);
        $display("test reset values done");
        for (int i = 0; i < 5; i++) begin
            v = $urandom;
            wr(ofs[i], v);
            rd(ofs[i], v & msk[i]);
        end
        for (int o = 0; o < 8; o++) begin
            wr(OFS_ORIENT, 32'(o));
            repeat (2) @(posedge clk);
            check(32'(orient), 32'(o));
        end
        $display("test fields and orientation done");
        wr(OFS_PCLK_DIV, 32'h2);
        wr(OFS_LINE_LEN, 32'h28);
        wr(OFS_FRAME_LEN, 32'h6);
        wr(OFS_DITHER, 32'h0);
        for (int f = 0; f < 8; f++) begin
            fr = 3'(f); fg = fr + 3'h3; fb = fr + 3'h5;
            wr(OFS_LINES, {23'h0, fr, fg, fb});
            pix_set <= doc_rgb_t'(24'($urandom));
            repeat (8) @(posedge clk);
            check(32'(rgb), 32'({pix_set.r & lmask(fr), pix_set.g & lmask(fg), pix_set.b & lmask(fb)}));
        end
        wr(OFS_DITHER, 32'h1);
        wr(OFS_LINES, 32'h0);
        pix_set <= doc_rgb_t'(24'($urandom));
        repeat (8) @(posedge clk);
        check(32'(rgb), 32'(pix_set));
        // one red line and a level just under it: plain output would stay dark, dithering must lift some pixels
        wr(OFS_LINES, 32'h00000040);
        pix_set <= doc_rgb_t'(24'h7f0000);
        repeat (8) @(posedge clk);
        hits = 0;
        repeat (16) begin
            @(posedge clk);
            if (rgb.r === 8'h80) hits++;
            check(32'(rgb.r & 8'h7f), 32'h0);
        end
        check(32'(hits != 0), 32'h1);
        $display("test colour lines done");
        wr(OFS_SYNC_A, 32'h1);
        wr(OFS_SYNC_B, 32'h2);
        while (fsync.phase_a !== 1'b0) @(posedge clk);
        while (fsync.phase_a !== 1'b1) @(posedge clk);
        run_len(1'b1, n);
        check(32'(n), 32'd80);
        run_len(1'b0, n);
        check(32'(n), 32'd160);
        $display("test frame sync done");
        wr(OFS_SWAP, 32'h1);
        rd(OFS_SWAP, 32'h1);
        wait_start(84, n);
        check(32'(lstart), 32'h1);
        rd(OFS_SWAP, 32'h0);
        wr(OFS_SWAP, 32'h2);
        rd(OFS_SWAP, 32'h2);
        wait_start(500, n);
        check(32'(lstart), 32'h1);
        repeat (2) @(posedge clk);
        check(32'(fsync.phase_a), 32'h1);
        rd(OFS_SWAP, 32'h0);
        check(32'(starts), 32'h2);
        $display("test swap done");
        wr(OFS_PCLK_DIV, 32'h4);
        repeat (10) @(posedge clk);
        count_rises(n);
        check(32'(n), 32'd10);
        $display("test pixel clock done");
        give_verdict();
    end
endmodule
`default_nettype wire
